// ===== design/otp_prom_port.sv
// serial one-time-programmable memory: read, programming mode, polarity and cascade logic
`timescale 1ns/10ps
module otp_prom_port
   import otp_port_pkg::*;
#(
   parameter int BURN_MIN = BURN_MIN_CYCLES,
   parameter int BURN_MAX = BURN_MAX_CYCLES
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic serial_clk,
   input wire logic chip_select_n,
   input wire logic reset_oe,
   input wire logic burn_level_supply,
   input wire logic entry_level_supply,
   input wire logic data_in,
   output logic data_out,
   output logic data_oe,
   output logic cascade_enable_out_n,
   output logic prog_mode,
   output logic burn_fault
);
   // ***************************************************************
   // pin synchronisers
   // ***************************************************************
   pins_t raw;
   pins_t s1_reg;
   pins_t s2_reg;
   pins_t s3_reg;
   pins_t pin_reg;
   logic sclk_prev_reg;
   logic burn_prev_reg;
   logic rise;

   assign raw = '{serial_clk, chip_select_n, reset_oe, data_in, burn_level_supply,
                  entry_level_supply};

   // three stages; a bit changes only once stages two and three agree
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s1_reg <= PINS_RESET;
         s2_reg <= PINS_RESET;
         s3_reg <= PINS_RESET;
         pin_reg <= PINS_RESET;
         sclk_prev_reg <= 1'b0;
         burn_prev_reg <= 1'b0;
      end
      else
      begin
         s1_reg <= raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         pin_reg <= (s2_reg & s3_reg) | (pin_reg & (s2_reg ^ s3_reg));
         sclk_prev_reg <= pin_reg.sclk;
         burn_prev_reg <= pin_reg.burn;
      end
   end

   assign rise = pin_reg.sclk && !sclk_prev_reg;

   // ***************************************************************
   // memory array
   // ***************************************************************
   logic [31:0] mem [0:MEM_DEPTH-1];
   logic [MEM_DEPTH-1:0] written_reg;
   logic [11:0] addr_reg;
   logic [11:0] addr_next;
   logic [4:0] bit_reg;
   logic [4:0] bit_next;
   logic [31:0] cur_word;
   logic [31:0] nxt_word;
   logic [31:0] pol_word;
   logic pol_high;

   function automatic logic pick_bit(input logic [31:0] word, input logic [4:0] idx);
      // words leave most significant bit first
      pick_bit = word[LAST_BIT - idx];
   endfunction : pick_bit

   // a word never burned reads as all ones, the blank state of the cells
   assign cur_word = written_reg[addr_reg] ? mem[addr_reg] : BLANK_WORD;
   assign nxt_word = written_reg[addr_next] ? mem[addr_next] : BLANK_WORD;
   assign pol_word = written_reg[OVERFLOW_ADDR] ? mem[OVERFLOW_ADDR] : BLANK_WORD;
   // only an all-zero word selects the active-low reset; blank stays active high
   assign pol_high = (pol_word != POL_LOW_WORD);

   // ***************************************************************
   // mode sequencer
   // ***************************************************************
   mode_t mode_reg;
   mode_t mode_next;
   logic sel_both_high;
   logic entry_edge;

   assign sel_both_high = pin_reg.cs_n && pin_reg.roe;
   assign entry_edge = rise && sel_both_high && pin_reg.entry && !pin_reg.burn;

   // two burn-level edges then one entry-level edge, selects high throughout
   always_comb
   begin
      mode_next = mode_reg;
      case (mode_reg)
         MODE_READ:
            if (rise && sel_both_high && pin_reg.burn)
               mode_next = MODE_ENTRY1;
         MODE_ENTRY1:
            if (rise)
               mode_next = (sel_both_high && pin_reg.burn) ? MODE_ENTRY2 : MODE_READ;
         MODE_ENTRY2:
            if (rise)
            begin
               if (sel_both_high && pin_reg.burn)
                  mode_next = MODE_ENTRY2;
               else if (entry_edge)
                  mode_next = MODE_PROG;
               else
                  mode_next = MODE_READ;
            end
         MODE_PROG:
            // both selects low ends the mode; power removal then resets us
            if (!pin_reg.cs_n && !pin_reg.roe)
               mode_next = MODE_READ;
         default:
            mode_next = MODE_READ;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         mode_reg <= MODE_READ;
      else
         mode_reg <= mode_next;
   end

   assign prog_mode = (mode_reg == MODE_PROG);

   // ***************************************************************
   // counters, shift paths and end-of-array flag
   // ***************************************************************
   logic counter_clear;
   logic out_enabled;
   logic end_reg;
   logic end_next;
   logic [31:0] shift_in_reg;
   logic [4:0] in_count_reg;
   logic in_ready;
   logic push;
   logic data_out_reg;

   // programmed polarity only sets the clear level outside programming mode; in programming mode it shows on the cascade output
   assign counter_clear = !prog_mode && (pol_high ? pin_reg.roe : !pin_reg.roe);
   assign out_enabled = !prog_mode && !counter_clear;
   assign push = prog_mode && rise && sel_both_high && in_ready && (in_count_reg == LAST_BIT);

   always_comb
   begin
      addr_next = addr_reg;
      bit_next = bit_reg;
      end_next = end_reg;
      if (counter_clear)
      begin
         addr_next = '0;
         bit_next = '0;
         end_next = 1'b0;
      end
      else if (!prog_mode)
      begin
         // select high freezes both counters
         if (rise && !pin_reg.cs_n && !end_reg)
         begin
            if (bit_reg == LAST_BIT)
            begin
               bit_next = '0;
               if (addr_reg == LAST_ADDR)
                  end_next = 1'b1;
               else
                  addr_next = addr_reg + 1'b1;
            end
            else
               bit_next = bit_reg + 1'b1;
         end
      end
      else if (rise && pin_reg.cs_n && !pin_reg.roe)
      begin
         // address step reaches the overflow word and holds there
         bit_next = '0;
         if (addr_reg != OVERFLOW_ADDR)
            addr_next = addr_reg + 1'b1;
      end
      else if (rise && !pin_reg.cs_n && pin_reg.roe && !end_reg)
      begin
         if (bit_reg == LAST_BIT)
         begin
            bit_next = '0;
            if (addr_reg == LAST_ADDR)
               end_next = 1'b1;
            else
               addr_next = addr_reg + 1'b1;
         end
         else
            bit_next = bit_reg + 1'b1;
      end
   end

   // entering programming mode starts from a clean counter state
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         addr_reg <= '0;
         bit_reg <= '0;
         end_reg <= 1'b0;
      end
      else if (mode_next == MODE_PROG && !prog_mode)
      begin
         addr_reg <= '0;
         bit_reg <= '0;
         end_reg <= 1'b0;
      end
      else
      begin
         addr_reg <= addr_next;
         bit_reg <= bit_next;
         end_reg <= end_next;
      end
   end

   // input shifting stalls while the buffer is full, so no word is lost
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         shift_in_reg <= '0;
         in_count_reg <= '0;
      end
      else if (prog_mode && rise && sel_both_high && in_ready)
      begin
         shift_in_reg <= {shift_in_reg[30:0], pin_reg.din};
         in_count_reg <= in_count_reg + 1'b1;
      end
      else if (prog_mode && rise && !pin_reg.cs_n)
      begin
         in_count_reg <= '0;
      end
   end

   // output bit tracks the counters one step ahead of the pin
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         data_out_reg <= 1'b1;
      else
         data_out_reg <= pick_bit(nxt_word, bit_next);
   end

   assign data_out = data_out_reg;
   // driver off past the end of the array so the next device can take over
   assign data_oe = !pin_reg.cs_n && !end_reg
                    && (prog_mode ? pin_reg.roe : out_enabled);
   // programming mode shows the polarity until final verification ends
   assign cascade_enable_out_n = prog_mode ? (!end_reg && pol_high)
                                 : !(end_reg && !pin_reg.cs_n);

   // ***************************************************************
   // burn path
   // ***************************************************************
   burn_entry_t push_entry;
   burn_entry_t head;
   logic head_valid;
   logic burn_take;
   logic pulse_end;
   logic pulse_ok;
   logic [BURN_CNT_W-1:0] burn_cnt_reg;

   assign push_entry = '{addr_reg, {shift_in_reg[30:0], pin_reg.din}};

   word_fifo #(.WIDTH($bits(burn_entry_t)), .DEPTH(FIFO_DEPTH)) burn_queue
   (
      .clk(clk),
      .reset_n(reset_n),
      .in_valid(push),
      .in_ready(in_ready),
      .in_data(push_entry),
      .out_valid(head_valid),
      .out_ready(burn_take),
      .out_data(head)
   );

   // pulse width measured in clk cycles, saturating well above the maximum
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         burn_cnt_reg <= '0;
      else if (prog_mode && pin_reg.burn)
      begin
         if (burn_cnt_reg != '1)
            burn_cnt_reg <= burn_cnt_reg + 1'b1;
      end
      else
         burn_cnt_reg <= '0;
   end

   assign pulse_end = prog_mode && burn_prev_reg && !pin_reg.burn;
   assign pulse_ok = (burn_cnt_reg >= BURN_CNT_W'(BURN_MIN))
                     && (burn_cnt_reg <= BURN_CNT_W'(BURN_MAX));
   assign burn_take = pulse_end && pulse_ok && head_valid;

   // cells can only go from one to zero
   always_ff @(posedge clk)
   begin
      if (burn_take)
         mem[head.addr] <= head.data & (written_reg[head.addr] ? mem[head.addr] : BLANK_WORD);
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         written_reg <= '0;
      else if (burn_take)
         written_reg[head.addr] <= 1'b1;
   end

   // a rejected or orphan pulse is flagged until programming mode is entered again
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         burn_fault <= 1'b0;
      else if (mode_reg == MODE_ENTRY2 && mode_next == MODE_PROG)
         burn_fault <= 1'b0;
      else if (pulse_end && !(pulse_ok && head_valid))
         burn_fault <= 1'b1;
   end

   // ***************************************************************
   // checks
   // ***************************************************************
   sequence entry_last_edge;
      mode_reg == MODE_ENTRY2 && entry_edge;
   endsequence

   sequence read_last_bit;
      !prog_mode && !counter_clear && rise && !pin_reg.cs_n && !end_reg
      && addr_reg == LAST_ADDR && bit_reg == LAST_BIT;
   endsequence

   mode_entry_a: assert property (@(posedge clk) disable iff (!reset_n)
      entry_last_edge |=> prog_mode)
      else $error("entry sequence did not reach programming mode");
   shift_in_a: assert property (@(posedge clk) disable iff (!reset_n)
      (prog_mode && rise && sel_both_high && in_ready) |=> shift_in_reg[0] == $past(pin_reg.din))
      else $error("data bit not shifted in");
   addr_step_a: assert property (@(posedge clk) disable iff (!reset_n)
      (prog_mode && rise && pin_reg.cs_n && !pin_reg.roe && addr_reg != OVERFLOW_ADDR)
      |=> addr_reg == $past(addr_reg) + 12'h001 && bit_reg == 5'h00)
      else $error("address did not step");
   shift_out_a: assert property (@(posedge clk) disable iff (!reset_n)
      (prog_mode && !pin_reg.cs_n && pin_reg.roe && !end_reg) |-> data_oe)
      else $error("data not driven during shift out");
   polarity_show_a: assert property (@(posedge clk) disable iff (!reset_n)
      (prog_mode && !end_reg) |-> cascade_enable_out_n == pol_high)
      else $error("polarity not shown on cascade output");
   counter_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
      (counter_clear && mode_next == MODE_READ) |=> addr_reg == 12'h000 && bit_reg == 5'h00)
      else $error("counters not cleared by reset level");
   standby_freeze_a: assert property (@(posedge clk) disable iff (!reset_n)
      (!prog_mode && pin_reg.cs_n && !counter_clear && mode_next == MODE_READ)
      |-> !data_oe ##1 ($stable(addr_reg) && $stable(bit_reg)))
      else $error("counters moved or data driven in standby");
   cascade_end_a: assert property (@(posedge clk) disable iff (!reset_n)
      read_last_bit ##1 (!pin_reg.cs_n && !counter_clear && !prog_mode)[*1]
      |-> !cascade_enable_out_n && !data_oe)
      else $error("cascade output not low after last bit");
   default_pol_a: assert property (@(posedge clk) disable iff (!reset_n)
      !written_reg[OVERFLOW_ADDR] |-> pol_high)
      else $error("blank polarity word not active high");
   prog_ignore_a: assert property (@(posedge clk) disable iff (!reset_n)
      prog_mode |-> !counter_clear)
      else $error("programmed polarity acted in programming mode");
endmodule : otp_prom_port

// ===== design/otp_port_pkg.sv
// constants, carriers and modes shared by the serial one-time-programmable memory port
package otp_port_pkg;
   // ***************************************************************
   // array geometry
   // ***************************************************************
   localparam int WORD_BITS = 32;
   localparam int ARRAY_WORDS = 2048;
   localparam int MEM_DEPTH = ARRAY_WORDS + 1; // array plus the polarity overflow word
   localparam int ADDR_W = 12;
   localparam int BIT_W = 5;
   localparam logic [11:0] LAST_ADDR = 12'h7FF;
   localparam logic [11:0] OVERFLOW_ADDR = 12'h800;
   localparam logic [4:0] LAST_BIT = 5'h1F;
   localparam logic [31:0] BLANK_WORD = 32'hFFFFFFFF;
   localparam logic [31:0] POL_LOW_WORD = 32'h00000000;

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int BURN_MIN_NS = 500000;
   localparam int BURN_MAX_NS = 1050000;
   localparam int BURN_MIN_CYCLES = (BURN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BURN_MAX_CYCLES = BURN_MAX_NS / CLK_PERIOD_NS;
   localparam int BURN_CNT_W = 18;
   localparam int FIFO_DEPTH = 16;

   // ***************************************************************
   // carriers and modes
   // ***************************************************************
   typedef struct packed
   {
      logic sclk;
      logic cs_n;
      logic roe;
      logic din;
      logic burn;
      logic entry;
   } pins_t;

   // idle pin picture: clock low, chip deselected, reset/oe high, supply at entry level
   localparam pins_t PINS_RESET = 6'h19;

   typedef struct packed
   {
      logic [11:0] addr;
      logic [31:0] data;
   } burn_entry_t;

   typedef enum {MODE_READ, MODE_ENTRY1, MODE_ENTRY2, MODE_PROG} mode_t;
endpackage : otp_port_pkg

// ===== design/word_fifo.sv
// small first-in first-out buffer with valid/ready on both sides
`timescale 1ns/10ps
module word_fifo
#(
   parameter int WIDTH = 44,
   parameter int DEPTH = 16
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [0:DEPTH-1];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [PW:0] count_reg;
   logic push;
   logic pop;

   // honest full and empty straight from the occupancy count
   assign in_ready = (count_reg != (PW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = store[rd_ptr_reg];

   // storage has no reset; only words below count_reg are ever presented
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         store[wr_ptr_reg] <= in_data;
      end
   end

   // pointers and occupancy
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         if (push && !pop)
         begin
            count_reg <= count_reg + 1'b1;
         end
         else if (pop && !push)
         begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

   fifo_bound_a: assert property (@(posedge clk) disable iff (!reset_n)
      count_reg <= (PW+1)'(DEPTH))
      else $error("fifo occupancy above depth");
endmodule : word_fifo

// ===== test/prom_programmer_model.sv
// programmer-side pin driver for the serial one-time-programmable memory port
`timescale 1ns/10ps
module prom_programmer_model
(
   input wire logic clk,
   output logic serial_clk,
   output logic chip_select_n,
   output logic reset_oe,
   output logic burn_level_supply,
   output logic entry_level_supply,
   output logic data_drv
);
   // ***************************************************************
   // pin levels and timing
   // ***************************************************************
   // idle picture: clock stands still low, chip deselected, supply at logic level
   initial
   begin
      serial_clk = 1'b0;
      chip_select_n = 1'b1;
      reset_oe = 1'b1;
      burn_level_supply = 1'b0;
      entry_level_supply = 1'b1;
      data_drv = 1'b0;
   end

   // six clocks, two more than the four the pin filter needs, so no level is caught mid-change
   task automatic settle();
      repeat (6) @(posedge clk);
   endtask : settle

   task automatic set_pins(input logic cs, input logic oe);
      @(posedge clk);
      chip_select_n <= cs;
      reset_oe <= oe;
      settle();
   endtask : set_pins

   // one serial clock period; the clock stands low between periods
   task automatic tick();
      @(posedge clk);
      serial_clk <= 1'b1;
      settle();
      serial_clk <= 1'b0;
      settle();
   endtask : tick

   // the supply pin sits at one level at a time: burn level or entry/logic level
   task automatic set_supply(input logic burn_on);
      burn_level_supply <= burn_on;
      entry_level_supply <= !burn_on;
   endtask : set_supply

   // ***************************************************************
   // programming sequences
   // ***************************************************************
   // burn level for two edges, then entry level for one, selects high throughout
   task automatic enter_prog();
      set_pins(1'b1, 1'b1);
      @(posedge clk);
      set_supply(1'b1);
      settle();
      tick();
      tick();
      set_supply(1'b0);
      settle();
      tick();
   endtask : enter_prog

   // word goes out msb first; on release the pin shows the inverse of the last bit
   task automatic shift_in(input logic [31:0] word);
      for (int i = 31; i >= 0; i--)
      begin
         data_drv <= word[i];
         settle();
         tick();
      end
      data_drv <= ~data_drv;
   endtask : shift_in

   // one supply strobe per queued word, length in system clocks
   task automatic burn(input int len);
      @(posedge clk);
      set_supply(1'b1);
      repeat (len) @(posedge clk);
      set_supply(1'b0);
      settle();
   endtask : burn

   // enable is only moved while the chip is deselected
   task automatic step(input int n);
      set_pins(1'b1, 1'b0);
      repeat (n) tick();
      set_pins(1'b1, 1'b1);
   endtask : step
endmodule : prom_programmer_model

// ===== test/test_otp_prom_port.sv
// self-checking bench for the serial one-time-programmable memory port
`timescale 1ns/10ps
module test_otp_prom_port
   import otp_port_pkg::*;
();
   // ***************************************************************
   // clock, reset and wiring
   // ***************************************************************
   localparam int TIMEOUT_CYCLES = 60000;
   localparam logic [31:0] WORD0 = 32'hA5C30F96;
   localparam logic [31:0] ONE = 32'h1;
   localparam logic [31:0] ZERO = 32'h0;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic serial_clk, chip_select_n, reset_oe, burn_level_supply, entry_level_supply;
   logic data_drv, data_in, data_out, data_oe, cascade_enable_out_n, prog_mode, burn_fault;
   logic [31:0] word;
   int n_fail = 0;
   int n_compared = 0;
   int cycles = 0;

   always #4 clk = ~clk;
   // the data pin carries the device's bit while it drives, else the programmer's
   assign data_in = data_oe ? data_out : data_drv;

   otp_prom_port #(.BURN_MIN(20), .BURN_MAX(40)) otp_prom_port_i
   (
      .clk(clk),
      .reset_n(reset_n),
      .serial_clk(serial_clk),
      .chip_select_n(chip_select_n),
      .reset_oe(reset_oe),
      .burn_level_supply(burn_level_supply),
      .entry_level_supply(entry_level_supply),
      .data_in(data_in),
      .data_out(data_out),
      .data_oe(data_oe),
      .cascade_enable_out_n(cascade_enable_out_n),
      .prog_mode(prog_mode),
      .burn_fault(burn_fault)
   );

   prom_programmer_model prom_programmer_model_i
   (
      .clk(clk),
      .serial_clk(serial_clk),
      .chip_select_n(chip_select_n),
      .reset_oe(reset_oe),
      .burn_level_supply(burn_level_supply),
      .entry_level_supply(entry_level_supply),
      .data_drv(data_drv)
   );

   // ***************************************************************
   // checking and closing
   // ***************************************************************
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : final_report

   // a hang in any handshake ends the run as a failure
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == TIMEOUT_CYCLES)
      begin
         n_fail++;
         final_report();
      end
   end

   // bits are taken before each serial clock, so the sample is long settled
   task automatic read_word(output logic [31:0] w);
      for (int i = 31; i >= 0; i--)
      begin
         w[i] = data_out;
         prom_programmer_model_i.tick();
      end
   endtask : read_word

   // ***************************************************************
   // scenarios
   // ***************************************************************
   // blank polarity word: reset pin high clears, low enables the output
   task automatic idle_after_reset();
      check("cascade_enable_out_n", cascade_enable_out_n, ONE);
      check("prog_mode", prog_mode, ZERO);
      check("burn_fault", burn_fault, ZERO);
      check("data_oe deselected", data_oe, ZERO);
      prom_programmer_model_i.set_pins(1'b0, 1'b0);
      check("data_oe selected", data_oe, ONE);
      check("data_out blank", data_out, ONE);
      prom_programmer_model_i.set_pins(1'b1, 1'b1);
   endtask : idle_after_reset

   // a good pulse burns the word; a pulse over the maximum width is flagged
   task automatic program_first_word();
      prom_programmer_model_i.enter_prog();
      check("prog_mode entered", prog_mode, ONE);
      check("cascade blank polarity", cascade_enable_out_n, ONE);
      prom_programmer_model_i.shift_in(WORD0);
      prom_programmer_model_i.burn(30);
      check("burn_fault good pulse", burn_fault, ZERO);
      prom_programmer_model_i.shift_in(BLANK_WORD);
      prom_programmer_model_i.burn(50);
      check("burn_fault long pulse", burn_fault, ONE);
      // a rejected pulse leaves its word queued; a good pulse drains it, cells unchanged
      prom_programmer_model_i.burn(30);
      check("burn_fault sticky", burn_fault, ONE);
      prom_programmer_model_i.set_pins(1'b0, 1'b0);
      check("prog_mode left", prog_mode, ZERO);
   endtask : program_first_word

   // read back word 0, then walk to the last word and watch the cascade output
   task automatic final_verification();
      prom_programmer_model_i.enter_prog();
      check("burn_fault cleared", burn_fault, ZERO);
      prom_programmer_model_i.set_pins(1'b0, 1'b1);
      read_word(word);
      check("word 0 readback", word, WORD0);
      prom_programmer_model_i.set_pins(1'b0, 1'b0);
      prom_programmer_model_i.enter_prog();
      prom_programmer_model_i.step(2047);
      prom_programmer_model_i.set_pins(1'b0, 1'b1);
      check("cascade before end", cascade_enable_out_n, ONE);
      read_word(word);
      check("last word blank", word, BLANK_WORD);
      check("cascade after end", cascade_enable_out_n, ZERO);
      check("data_oe after end", data_oe, ZERO);
      prom_programmer_model_i.set_pins(1'b1, 1'b1);
      prom_programmer_model_i.step(1);
      prom_programmer_model_i.shift_in(POL_LOW_WORD);
      prom_programmer_model_i.burn(30);
      check("burn_fault polarity", burn_fault, ZERO);
      prom_programmer_model_i.set_pins(1'b0, 1'b0);
   endtask : final_verification

   // zero polarity word: reset pin low clears, high enables; ignored in programming
   task automatic polarity_low();
      prom_programmer_model_i.enter_prog();
      check("prog_mode low polarity", prog_mode, ONE);
      check("cascade zero polarity", cascade_enable_out_n, ZERO);
      prom_programmer_model_i.set_pins(1'b0, 1'b1);
      read_word(word);
      check("word 0 in prog", word, WORD0);
      prom_programmer_model_i.set_pins(1'b0, 1'b0);
      check("data_oe reset low", data_oe, ZERO);
      prom_programmer_model_i.set_pins(1'b0, 1'b1);
      check("data_oe enable high", data_oe, ONE);
      check("bit 31 after clear", data_out, ONE);
      prom_programmer_model_i.tick();
      check("bit 30", data_out, ZERO);
      prom_programmer_model_i.set_pins(1'b1, 1'b1);
      check("data_oe standby", data_oe, ZERO);
      prom_programmer_model_i.tick();
      prom_programmer_model_i.set_pins(1'b0, 1'b1);
      check("bit 30 frozen", data_out, ZERO);
      prom_programmer_model_i.tick();
      check("bit 29", data_out, ONE);
   endtask : polarity_low

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial
   begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      repeat (6) @(posedge clk);
      idle_after_reset();
      program_first_word();
      final_verification();
      polarity_low();
      final_report();
   end
endmodule : test_otp_prom_port
